// ==== hw/stsu_pkg.sv ====
// Constants and types of the skip test and shift unit.
// Assumes a 12-bit word and octal opcodes as split into two 6-bit fields.
package stsu_pkg;

  localparam int WORD_W = 12;
  localparam int DWORD_W = 24;

  typedef logic [11:0] stsu_word_type;
  typedef logic [5:0] stsu_field_type;

  typedef struct packed {
    stsu_word_type first_accumulator;
    stsu_word_type second_accumulator;
  } stsu_acc_pair_type;

  typedef enum logic [2:0] {
    SH_NONE,
    SH_RIGHT_LOGICAL,
    SH_RIGHT_ARITH,
    SH_LEFT,
    SH_ROTATE
  } stsu_shift_kind_type;

  // ****************************************************************
  // Upper opcode field (octal 40, 41, 60, 61, 31, 12)
  // ****************************************************************
  localparam stsu_field_type PFX_DBL_FIRST = 6'h20;
  localparam stsu_field_type PFX_DBL_SECOND = 6'h21;
  localparam stsu_field_type PFX_SGL_FIRST = 6'h30;
  localparam stsu_field_type PFX_SGL_SECOND = 6'h31;
  localparam stsu_field_type PFX_DEC_SKIP = 6'h19;
  localparam stsu_field_type PFX_MODIFY = 6'h0A;

  // ****************************************************************
  // Lower opcode field
  // ****************************************************************
  localparam logic [3:0] SHIFT_MAX = 4'hB;
  localparam logic [3:0] BIT_MAX = 4'hC;
  localparam logic [3:0] ZERO_LE = 4'hD;
  localparam logic [3:0] ZERO_SWAP = 4'hE;
  localparam logic [3:0] ZERO_SAME = 4'hF;
  localparam stsu_field_type CMP_ORDER_A = 6'h2C;
  localparam stsu_field_type CMP_NE = 6'h2E;
  localparam stsu_field_type CMP_ORDER_B = 6'h3C;
  localparam stsu_field_type CMP_EQ = 6'h3E;

  localparam stsu_word_type PC_STEP = 12'h001;
  localparam stsu_word_type PC_SKIP_STEP = 12'h003;
  localparam stsu_word_type WORD_ONE = 12'h001;
  localparam stsu_word_type WORD_ZERO = 12'h000;

endpackage : stsu_pkg

// ==== hw/stsu_shifter.sv ====
// Combinational barrel shifter for one or both accumulators.
// Assumes the count never exceeds eleven; the decoder guarantees it.
`timescale 1ns/1ns
module stsu_shifter (
  input wire stsu_pkg::stsu_acc_pair_type acc_i,
  input wire stsu_pkg::stsu_shift_kind_type kind_i,
  input wire logic dbl_i,
  input wire logic second_i,
  input wire logic [3:0] count_i,
  output stsu_pkg::stsu_acc_pair_type acc_o
);
  import stsu_pkg::*;

  // First accumulator is the upper half of the double word
  wire [23:0] dv = {acc_i.first_accumulator, acc_i.second_accumulator};
  wire [11:0] sv = second_i ? acc_i.second_accumulator :
                   acc_i.first_accumulator;
  wire [4:0] dback = 5'(DWORD_W - int'(count_i));
  wire [3:0] sback = 4'(WORD_W - int'(count_i));

  wire [23:0] d_rl = dv >> count_i;
  // Fill comes from the first accumulator sign bit
  wire [23:0] d_ra = 24'($signed(dv) >>> count_i);
  wire [23:0] d_l = dv << count_i;
  // Count zero gives dv << 24, which is zero, so no wrap
  wire [23:0] d_rot = (dv >> count_i) | (dv << dback);

  wire [11:0] s_rl = sv >> count_i;
  wire [11:0] s_ra = 12'($signed(sv) >>> count_i);
  wire [11:0] s_l = sv << count_i;
  wire [11:0] s_rot = (count_i == 4'h0) ? sv :
                      ((sv >> count_i) | (sv << sback));

  wire [23:0] d_res = (kind_i == SH_RIGHT_LOGICAL) ? d_rl :
                      (kind_i == SH_RIGHT_ARITH) ? d_ra :
                      (kind_i == SH_LEFT) ? d_l :
                      (kind_i == SH_ROTATE) ? d_rot : dv;
  wire [11:0] s_res = (kind_i == SH_RIGHT_LOGICAL) ? s_rl :
                      (kind_i == SH_RIGHT_ARITH) ? s_ra :
                      (kind_i == SH_LEFT) ? s_l :
                      (kind_i == SH_ROTATE) ? s_rot : sv;

  assign acc_o = dbl_i ? stsu_acc_pair_type'(d_res) :
                 second_i ? {acc_i.first_accumulator, s_res} :
                 {s_res, acc_i.second_accumulator};

endmodule : stsu_shifter

// ==== hw/stsu_skip_eval.sv ====
// Skip condition evaluation for the octal 40 and 41 opcode groups.
// Assumes the caller has already removed shift codes from the group.
`timescale 1ns/1ns
module stsu_skip_eval (
  input wire stsu_pkg::stsu_field_type low_i,
  input wire logic second_i,
  input wire stsu_pkg::stsu_acc_pair_type acc_i,
  input wire logic overflow_i,
  output logic cond_o
);
  import stsu_pkg::*;

  wire signed [11:0] a1 = acc_i.first_accumulator;
  wire signed [11:0] a2 = acc_i.second_accumulator;
  wire [11:0] tst = second_i ? acc_i.second_accumulator :
                    acc_i.first_accumulator;
  wire [3:0] n = low_i[3:0];
  wire want_set = low_i[4];
  wire [3:0] n_idx = n - 4'h1;
  // Bits counted from one at the least significant end
  wire bit_val = tst[n_idx];
  wire bit_test = (n >= 4'h1) && (n <= BIT_MAX);
  wire bit_cond = want_set ? bit_val : ~bit_val;
  wire ovf_cond = want_set ? overflow_i : ~overflow_i;

  // Code E swaps the accumulator of the zero tests in both groups
  wire zero_a1 = (a1 == 12'sh000);
  wire zero_a2 = (a2 == 12'sh000);
  wire sw_zero = second_i ? zero_a1 : zero_a2;
  wire same_zero = second_i ? zero_a2 : zero_a1;
  wire le_zero = second_i ? (a2 <= 12'sh000) : (a1 <= 12'sh000);
  wire zt_eq = (n == ZERO_SAME) ? same_zero :
               (n == ZERO_SWAP) ? sw_zero : le_zero;
  wire zt_set = (n == ZERO_SAME) ? !same_zero :
                (n == ZERO_SWAP) ? !sw_zero :
                (!second_i && (a1 > 12'sh000));
  wire zero_cond = want_set ? zt_set : zt_eq;

  wire [5:0] cmp = {low_i[5:1], 1'b0};
  // The four ordering codes decide greater, less, at most and at least
  wire cmp_cond = (cmp == CMP_EQ) ? (a1 == a2) :
                  (cmp == CMP_NE) ? (a1 != a2) :
                  (cmp == CMP_ORDER_A) ? (second_i ? a1 < a2 : a1 > a2) :
                  (cmp == CMP_ORDER_B) ? (second_i ? a1 >= a2 : a1 <= a2) :
                  1'b0;

  assign cond_o = low_i[5] ? cmp_cond :
                  (n == 4'h0) ? ovf_cond :
                  bit_test ? bit_cond : zero_cond;

endmodule : stsu_skip_eval

// ==== hw/stsu_unit.sv ====
// Skip test, decrement-and-skip and shift unit of a 12-bit logic unit.
// Assumes the sequencer presents one decoded word per op_valid_i pulse,
// with the addressed register already on reg_data_i in that cycle.
//
// Function
// - True skip condition moves program counter past the next two words.
// - Tested accumulator bits are numbered one to twelve from the bottom.
// - Bit-clear codes 4000/4100 plus N, bit-set codes 4020/4120 plus N.
// - Accumulator compare codes decode to equal, not equal, greater, less and order.
// - The four ordering codes decide greater, less, at most and at least.
// - Decrement-and-skip lowers the register and skips when result zero.
// - Decremented register is written back whether or not it skips.
// - Shifts take counts zero to eleven on one or both accumulators.
// - Shift count comes from the register field of the instruction.
// - Modify-next adds a register to the following instruction word.
// - First single shifts: logical 6060, arithmetic 6000, left 6020.
// - Second accumulator single shifts are the same codes plus 100.
// - Single rotates decode as 6040 and 6140 plus N.
// - Double shifts decode as 4040, 4140 and 4160 plus N.
// - Double rotate decodes as 4060 plus N.
// - Logical right shifts fill the top with zeros.
// - Arithmetic right shifts fill the top with the sign.
// - Left shifts fill the bottom with zeros.
// - Double right moves first low bit into second top bit.
// - Double left moves second top bit into first low bit.
// - Single rotate feeds the low bit back to the top.
// - Double rotate wraps second low bit into first top bit.
`timescale 1ns/1ns
module stsu_unit (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic op_valid_i,
  input wire stsu_pkg::stsu_word_type op_word_i,
  input wire stsu_pkg::stsu_word_type reg_data_i,
  input wire logic overflow_i,
  input wire logic acc_load_i,
  input wire stsu_pkg::stsu_acc_pair_type acc_load_data_i,
  input wire logic pc_load_i,
  input wire stsu_pkg::stsu_word_type pc_load_value_i,
  output stsu_pkg::stsu_acc_pair_type acc_o,
  output stsu_pkg::stsu_word_type pc_o,
  output logic skip_o,
  output logic op_done_o,
  output logic reg_wr_o,
  output stsu_pkg::stsu_field_type reg_addr_o,
  output stsu_pkg::stsu_word_type reg_wdata_o
);
  import stsu_pkg::*;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  logic mdi_pending;
  stsu_word_type modifier;
  stsu_acc_pair_type acc;
  stsu_word_type pc;

  // Program memory stays unchanged; only this copy is modified
  wire [11:0] op_eff = mdi_pending ? op_word_i + modifier : op_word_i;
  wire [5:0] pfx = op_eff[11:6];
  wire [5:0] low = op_eff[5:0];
  wire [3:0] count = low[3:0];
  wire sel_second = pfx[0];
  wire count_ok = (count <= SHIFT_MAX);

  wire grp_dbl = (pfx == PFX_DBL_FIRST) || (pfx == PFX_DBL_SECOND);
  wire grp_sgl = (pfx == PFX_SGL_FIRST) || (pfx == PFX_SGL_SECOND);
  wire is_dbl_shift = grp_dbl && low[5] && count_ok;
  wire is_sgl_shift = grp_sgl && count_ok;
  wire is_skip = grp_dbl && !is_dbl_shift;
  wire is_dec = (pfx == PFX_DEC_SKIP);
  wire is_mdi = (pfx == PFX_MODIFY);

  // Double group: 40 logical, 60 rotate; under 41: arithmetic, left
  wire [2:0] dbl_kind = low[4] ?
    (sel_second ? SH_LEFT : SH_ROTATE) :
    (sel_second ? SH_RIGHT_ARITH : SH_RIGHT_LOGICAL);
  // Single group order: arithmetic, left, rotate, logical
  wire [2:0] sgl_kind = (low[5:4] == 2'h0) ? SH_RIGHT_ARITH :
                        (low[5:4] == 2'h1) ? SH_LEFT :
                        (low[5:4] == 2'h2) ? SH_ROTATE :
                        SH_RIGHT_LOGICAL;
  wire [2:0] kind_raw = is_dbl_shift ? dbl_kind :
                        is_sgl_shift ? sgl_kind : SH_NONE;
  wire stsu_shift_kind_type kind = stsu_shift_kind_type'(kind_raw);

  // ****************************************************************
  // Datapath
  // ****************************************************************
  stsu_acc_pair_type shifted;
  logic skip_cond;

  stsu_shifter u_shifter (
    .acc_i(acc),
    .kind_i(kind),
    .dbl_i(is_dbl_shift),
    .second_i(sel_second),
    .count_i(count),
    .acc_o(shifted)
  );

  stsu_skip_eval u_skip (
    .low_i(low),
    .second_i(sel_second),
    .acc_i(acc),
    .overflow_i(overflow_i),
    .cond_o(skip_cond)
  );

  wire [11:0] dec_value = reg_data_i - WORD_ONE;
  wire dec_zero = (dec_value == WORD_ZERO);
  wire take_skip = (is_skip && skip_cond) || (is_dec && dec_zero);
  wire [11:0] pc_step = take_skip ? PC_SKIP_STEP : PC_STEP;

  wire stsu_acc_pair_type next_acc = acc_load_i ? acc_load_data_i :
    (op_valid_i ? shifted : acc);
  wire [11:0] next_pc = pc_load_i ? pc_load_value_i :
    (op_valid_i ? pc + pc_step : pc);
  // Any executed word consumes a pending modify
  wire next_mdi = op_valid_i ? is_mdi : mdi_pending;
  wire [11:0] next_modifier = op_valid_i ? reg_data_i : modifier;

  // ****************************************************************
  // State
  // ****************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc <= '0;
      pc <= WORD_ZERO;
      mdi_pending <= 1'b0;
      modifier <= WORD_ZERO;
    end else begin
      acc <= next_acc;
      pc <= next_pc;
      mdi_pending <= next_mdi;
      modifier <= next_modifier;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      skip_o <= 1'b0;
      op_done_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_addr_o <= '0;
      reg_wdata_o <= WORD_ZERO;
    end else begin
      skip_o <= op_valid_i && take_skip;
      op_done_o <= op_valid_i;
      // Written back on both outcomes of the test
      reg_wr_o <= op_valid_i && is_dec;
      reg_addr_o <= low;
      reg_wdata_o <= dec_value;
    end
  end

  assign acc_o = acc;
  assign pc_o = pc;

  // ****************************************************************
  // Checks
  // ****************************************************************
  wire op_plain = op_valid_i && !acc_load_i && !pc_load_i;
  wire cmp_eq_code = is_skip && (low[5:1] == CMP_EQ[5:1]);
  wire cmp_ne_code = is_skip && (low[5:1] == CMP_NE[5:1]);
  // Low 00 and 20 of the skip group test overflow
  wire ovf_code = is_skip && !low[5] && (count == 4'h0);

  sequence s_mdi_issued;
    op_valid_i && is_mdi;
  endsequence

  sequence s_next_op;
    op_valid_i;
  endsequence

  a_skip_pc_adv: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && take_skip |=> skip_o && pc_o == $past(pc) + PC_SKIP_STEP)
    else $error("skip did not pass two words");

  a_noskip_pc_step: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && !take_skip |=> !skip_o && pc_o == $past(pc) + PC_STEP)
    else $error("untaken skip moved pc wrongly");

  a_dec_writeback: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && is_dec |=> reg_wr_o && op_done_o &&
      reg_wdata_o == $past(reg_data_i) - WORD_ONE)
    else $error("decrement not written back");

  a_dec_skip_one: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && is_dec && reg_data_i == WORD_ONE |=> skip_o)
    else $error("decrement to zero did not skip");

  a_mdi_modify: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s_mdi_issued ##1 s_next_op |-> op_eff == op_word_i + $past(reg_data_i))
    else $error("next instruction not modified");

  a_zero_count: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && (is_dbl_shift || is_sgl_shift) && count == 4'h0
    |=> acc == $past(acc))
    else $error("zero shift changed accumulators");

  // First low bit lands count minus one places below the top of the second
  a_dbl_logic_fill: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_dbl_shift && kind == SH_RIGHT_LOGICAL && count != 4'h0
    |=> !acc.first_accumulator[11] &&
      acc.second_accumulator[4'(WORD_W) - $past(count)] ==
      $past(acc.first_accumulator[0]))
    else $error("double logical shift fill wrong");

  a_arith_sign_fill: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_dbl_shift && kind == SH_RIGHT_ARITH
    |=> acc.first_accumulator[11] == $past(acc.first_accumulator[11]))
    else $error("arithmetic shift lost sign");

  a_left_fill: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_dbl_shift && kind == SH_LEFT && count == 4'h1
    |=> !acc.second_accumulator[0] &&
      acc.first_accumulator[0] == $past(acc.second_accumulator[11]))
    else $error("double left shift fill wrong");

  // Decode is taken from the issuing cycle, not the following one
  a_rotate_wrap: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && kind == SH_ROTATE && count == 4'h1
    |=> ($past(is_dbl_shift) ?
      acc.first_accumulator[11] == $past(acc.second_accumulator[0]) :
      $past(sel_second) ?
      acc.second_accumulator[11] == $past(acc.second_accumulator[0]) :
      acc.first_accumulator[11] == $past(acc.first_accumulator[0])))
    else $error("rotate did not wrap low bit");

  // ****************************************************************
  // Decode and side-effect checks
  // ****************************************************************
  a_done_pulse: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i |=> op_done_o)
    else $error("executed word gave no done pulse");

  a_idle_quiet: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !op_valid_i |=> !op_done_o && !skip_o && !reg_wr_o)
    else $error("pulse without an executed word");

  a_dec_no_skip: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && is_dec && reg_data_i != WORD_ONE |=> !skip_o)
    else $error("nonzero decrement skipped");

  a_dec_reg_addr: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && is_dec |=> reg_addr_o == $past(op_eff[5:0]))
    else $error("decrement wrote the wrong register");

  a_dec_write_only: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && !is_dec |=> !reg_wr_o)
    else $error("register written by a non-decrement word");

  a_skip_acc_kept: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && (is_skip || is_dec || is_mdi)
    |=> acc == $past(acc))
    else $error("non-shift word changed accumulators");

  a_count_limit: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && grp_sgl && !count_ok |=> acc == $past(acc))
    else $error("count above eleven shifted");

  a_eq_decision: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && cmp_eq_code |=> skip_o ==
      ($past(acc.first_accumulator) == $past(acc.second_accumulator)))
    else $error("equality skip decided wrongly");

  a_ne_decision: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && cmp_ne_code |=> skip_o ==
      ($past(acc.first_accumulator) != $past(acc.second_accumulator)))
    else $error("inequality skip decided wrongly");

  a_ovf_decision: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && ovf_code |=> skip_o == ($past(overflow_i) == $past(low[4])))
    else $error("overflow skip decided wrongly");

  a_sgl_other_kept: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_sgl_shift |=> ($past(sel_second) ?
      acc.first_accumulator == $past(acc.first_accumulator) :
      acc.second_accumulator == $past(acc.second_accumulator)))
    else $error("single shift touched the other accumulator");

  a_sgl_logic_fill: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_sgl_shift && kind == SH_RIGHT_LOGICAL && count != 4'h0
    |=> !($past(sel_second) ? acc.second_accumulator[11] :
      acc.first_accumulator[11]))
    else $error("single logical shift fill wrong");

  a_sgl_left_fill: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_plain && is_sgl_shift && kind == SH_LEFT && count != 4'h0
    |=> !($past(sel_second) ? acc.second_accumulator[0] :
      acc.first_accumulator[0]))
    else $error("single left shift fill wrong");

  a_mdi_cleared: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    op_valid_i && !is_mdi |=> !mdi_pending)
    else $error("modify stayed pending after a word");

endmodule : stsu_unit

// ==== verif/stsu_seq_model.sv ====
// Register file model standing behind the skip test and shift unit.
// Assumes the unit reads the register named by the low six bits of the
// presented word and writes back through its one-cycle write strobe.
`timescale 1ns/1ns
module stsu_seq_model (
  input wire logic clk_i,
  input wire stsu_pkg::stsu_word_type op_word_i,
  input wire logic reg_wr_i,
  input wire stsu_pkg::stsu_field_type reg_addr_i,
  input wire stsu_pkg::stsu_word_type reg_wdata_i,
  output stsu_pkg::stsu_word_type reg_data_o
);
  import stsu_pkg::*;

  stsu_word_type regs [0:63];

  // Each register starts at its own index, so no preload path is needed
  initial begin
    for (int i = 0; i < 64; i++) begin
      regs[i] = 12'(i);
    end
  end

  assign reg_data_o = regs[op_word_i[5:0]];

  always @(posedge clk_i) begin
    if (reg_wr_i) begin
      regs[reg_addr_i] <= reg_wdata_i;
    end
  end

endmodule : stsu_seq_model

// ==== verif/stsu_unit_tb.sv ====
// Self-checking testbench of the skip test and shift unit.
// Assumes the register file model answers the register read path.
`timescale 1ns/1ns
module stsu_unit_tb;
  import stsu_pkg::*;

  typedef struct {
    stsu_word_type w, a1, a2, e1, e2;
    logic ov, sk;
  } stsu_row_type;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic op_valid_i = 1'b0;
  stsu_word_type op_word_i = 12'h000;
  stsu_word_type reg_data_i;
  logic overflow_i = 1'b0;
  logic acc_load_i = 1'b0;
  stsu_acc_pair_type acc_load_data_i = 24'h000000;
  logic pc_load_i = 1'b0;
  stsu_word_type pc_load_value_i = 12'h000;
  stsu_acc_pair_type acc_o;
  stsu_word_type pc_o, reg_wdata_o;
  logic skip_o, op_done_o, reg_wr_o;
  stsu_field_type reg_addr_o;
  int n_fail = 0;
  int n_checks = 0;
  stsu_row_type rows[$];

  always #4 clk_i = ~clk_i;

  stsu_unit stsu_unit_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .op_valid_i(op_valid_i), .op_word_i(op_word_i),
    .reg_data_i(reg_data_i), .overflow_i(overflow_i),
    .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i),
    .pc_load_i(pc_load_i), .pc_load_value_i(pc_load_value_i),
    .acc_o(acc_o), .pc_o(pc_o), .skip_o(skip_o), .op_done_o(op_done_o),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o));

  stsu_seq_model stsu_seq_model_inst (.clk_i(clk_i), .op_word_i(op_word_i),
    .reg_wr_i(reg_wr_o), .reg_addr_i(reg_addr_o),
    .reg_wdata_i(reg_wdata_o), .reg_data_o(reg_data_i));

  // ******************************************************
  // Helpers
  // ******************************************************
  // Opcodes are written as their four octal digits
  function automatic stsu_word_type oc(input int d);
    return {3'(d / 1000), 3'(d / 100 % 10), 3'(d / 10 % 10), 3'(d % 10)};
  endfunction : oc

  task automatic chk_w(input string nm, input stsu_word_type e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b got %b", nm, e, g);
    end
  endtask : chk_b

  task automatic sk(input int w, input stsu_word_type a1, a2,
                    input logic ov, s);
    rows.push_back('{oc(w), a1, a2, a1, a2, ov, s});
  endtask : sk

  task automatic sh(input int w, input stsu_word_type a1, a2, e1, e2);
    rows.push_back('{oc(w), a1, a2, e1, e2, 1'b0, 1'b0});
  endtask : sh

  // Accumulators and program counter are preset one edge ahead
  task automatic prep(input stsu_word_type a1, a2, input logic ov);
    @(posedge clk_i);
    acc_load_i <= 1'b1;
    acc_load_data_i <= {a1, a2};
    pc_load_i <= 1'b1;
    pc_load_value_i <= 12'h100;
    overflow_i <= ov;
  endtask : prep

  task automatic issue(input stsu_word_type w);
    @(posedge clk_i);
    acc_load_i <= 1'b0;
    pc_load_i <= 1'b0;
    op_valid_i <= 1'b1;
    op_word_i <= w;
  endtask : issue

  task automatic settle;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
  endtask : settle

  task automatic dec(input stsu_field_type f, input stsu_word_type e,
                     input logic s);
    prep(12'h000, 12'h000, 1'b0);
    issue(oc(3100) | {6'h00, f});
    settle;
    chk_b("reg_wr", 1'b1, reg_wr_o);
    chk_w("reg_addr", {6'h00, f}, {6'h00, reg_addr_o});
    chk_w("reg_wdata", e, reg_wdata_o);
    chk_b("dec_skip", s, skip_o);
    chk_w("dec_pc", s ? 12'h103 : 12'h101, pc_o);
  endtask : dec

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end

  // ******************************************************
  // Main sequence
  // ******************************************************
  initial begin
    sk(4076, 12'h005, 12'h005, 1'b0, 1'b1);
    sk(4177, 12'h005, 12'h006, 1'b0, 1'b0);
    sk(4054, 12'h006, 12'h005, 1'b0, 1'b1);
    sk(4155, 12'h006, 12'h005, 1'b0, 1'b0);
    sk(4154, 12'hFFF, 12'h001, 1'b0, 1'b1);
    sk(4074, 12'h003, 12'h003, 1'b0, 1'b1);
    sk(4174, 12'h002, 12'h003, 1'b0, 1'b0);
    sk(4056, 12'h001, 12'h002, 1'b0, 1'b1);
    sk(4057, 12'h001, 12'h002, 1'b0, 1'b1);
    sk(4156, 12'h001, 12'h002, 1'b0, 1'b1);
    sk(4157, 12'h003, 12'h003, 1'b0, 1'b0);
    sk(4020, 12'h000, 12'h000, 1'b1, 1'b1);
    sk(4100, 12'h000, 12'h000, 1'b1, 1'b0);
    sk(4001, 12'hFFE, 12'h000, 1'b0, 1'b1);
    sk(4014, 12'h7FF, 12'h000, 1'b0, 1'b1);
    sk(4134, 12'h000, 12'h800, 1'b0, 1'b1);
    sk(4121, 12'h000, 12'h000, 1'b0, 1'b0);
    sk(4116, 12'h000, 12'h005, 1'b0, 1'b1);
    sh(6063, 12'h800, 12'h123, 12'h100, 12'h123);
    sh(6003, 12'h800, 12'h123, 12'hF00, 12'h123);
    sh(6023, 12'h801, 12'h123, 12'h008, 12'h123);
    sh(6043, 12'h00F, 12'h123, 12'hE01, 12'h123);
    sh(6163, 12'hABC, 12'h800, 12'hABC, 12'h100);
    sh(6103, 12'hABC, 12'h800, 12'hABC, 12'hF00);
    sh(6123, 12'hABC, 12'h801, 12'hABC, 12'h008);
    sh(6143, 12'hABC, 12'h00F, 12'hABC, 12'hE01);
    sh(6041, 12'h001, 12'h123, 12'h800, 12'h123);
    sh(6141, 12'hABC, 12'h001, 12'hABC, 12'h800);
    sh(6014, 12'hABC, 12'h123, 12'hABC, 12'h123);
    sh(6013, 12'h800, 12'h123, 12'hFFF, 12'h123);
    sh(6000, 12'hABC, 12'h123, 12'hABC, 12'h123);
    sh(4041, 12'h800, 12'h000, 12'h400, 12'h000);
    sh(4044, 12'h001, 12'h000, 12'h000, 12'h100);
    sh(4144, 12'h800, 12'h000, 12'hF80, 12'h000);
    sh(4161, 12'h000, 12'h800, 12'h001, 12'h000);
    sh(4061, 12'h000, 12'h001, 12'h800, 12'h000);
    sh(4053, 12'h800, 12'h000, 12'h001, 12'h000);
    sh(4040, 12'hABC, 12'hDEF, 12'hABC, 12'hDEF);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk_w("reset_first_accumulator", 12'h000, acc_o.first_accumulator);
    chk_w("reset_pc", 12'h000, pc_o);
    chk_b("reset_done", 1'b0, op_done_o);
    chk_b("reset_skip", 1'b0, skip_o);
    foreach (rows[i]) begin
      prep(rows[i].a1, rows[i].a2, rows[i].ov);
      issue(rows[i].w);
      settle;
      chk_w("first_accumulator", rows[i].e1, acc_o.first_accumulator);
      chk_w("second_accumulator", rows[i].e2, acc_o.second_accumulator);
      chk_b("skip", rows[i].sk, skip_o);
      chk_w("pc", rows[i].sk ? 12'h103 : 12'h101, pc_o);
      chk_b("done", 1'b1, op_done_o);
    end
    // ****************************************************
    // Decrement write-back and modify-next
    // ****************************************************
    dec(6'h01, 12'h000, 1'b1);
    dec(6'h01, 12'hFFF, 1'b0);
    dec(6'h02, 12'h001, 1'b0);
    dec(6'h02, 12'h000, 1'b1);
    // Register three holds three, turning the zero count into three
    prep(12'h800, 12'h123, 1'b0);
    issue(oc(1203));
    issue(oc(6060));
    settle;
    chk_w("mod_first_accumulator", 12'h100, acc_o.first_accumulator);
    chk_w("mod_pc", 12'h102, pc_o);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    #1;
    chk_w("rerun_first_accumulator", 12'h000, acc_o.first_accumulator);
    chk_w("rerun_pc", 12'h000, pc_o);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk_w("rerun_pc2", 12'h000, pc_o);
    chk_b("rerun_done", 1'b0, op_done_o);
    stop_test;
  end

endmodule : stsu_unit_tb
